// ### verilog/udc_pkg.sv
// Package of constants for the dual-input up/down counter
package udc_pkg;
    localparam int UDC_WIDTH = 4;
    localparam logic [3:0] UDC_ZERO = 4'h0;
    localparam logic [3:0] UDC_DEC_MAX = 4'h9;
    localparam logic [3:0] UDC_BIN_MAX = 4'hf;
    localparam logic [3:0] UDC_ONE = 4'h1;
endpackage : udc_pkg

// ### verilog/udc_edge_if.sv
// Interface carrying the unregistered count input levels and their rising-edge events
`timescale 1ns/1ps
interface udc_edge_if;
    logic up_lvl;
    logic dn_lvl;
    logic up_rise;
    logic dn_rise;
    modport det (output up_lvl, output dn_lvl, output up_rise, output dn_rise);
    modport core (input up_lvl, input dn_lvl, input up_rise, input dn_rise);
endinterface : udc_edge_if

// ### verilog/udc_edge_det.sv
// Rising-edge detector for the two count inputs
`timescale 1ns/1ps
module udc_edge_det
    import udc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic up_in,
    input wire logic dn_in,
    udc_edge_if.det eif
);
    typedef struct packed {
        logic up_d;
        logic dn_d;
    } udc_det_state_type;

    udc_det_state_type st_r;
    udc_det_state_type st_nxt;

    always_comb begin
        st_nxt.up_d = up_in;
        st_nxt.dn_d = dn_in;
    end

    // Idle level high, so reset keeps a high input from looking like an edge
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '{up_d: 1'b1, dn_d: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign eif.up_lvl = up_in;
    assign eif.dn_lvl = dn_in;
    assign eif.up_rise = up_in & ~st_r.up_d;
    assign eif.dn_rise = dn_in & ~st_r.dn_d;
endmodule : udc_edge_det

// ### verilog/udc_counter.sv
// Four-bit up/down counter with clear, parallel load, carry and borrow
`timescale 1ns/1ps
// Function
// - Four-bit count, up, down and clear inputs
// - Clear zeroes count, overrides everything else
// - Load low copies data inputs to count
// - Decade up wraps nine to zero, carry
// - Decade down wraps zero to nine, borrow
// - Binary up wraps fifteen to zero, carry
// - Binary down wraps zero to fifteen, borrow
// - Count changes on rising edge of pulsed input
// - Preset acts while load low, ignoring counts
// - Clear is active high
// - Borrow follows count-down low phase at underflow
module udc_counter
    import udc_pkg::*;
#(
    parameter bit DECADE = 1'b0
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Count and control inputs
    input wire logic COUNT_UP,
    input wire logic COUNT_DN,
    input wire logic CLEAR,
    input wire logic LOAD_N,
    input wire logic [UDC_WIDTH-1:0] DATA,
    // Count and cascade outputs
    output logic [UDC_WIDTH-1:0] Q,
    output logic CARRY_N,
    output logic BORROW_N
);
    localparam logic [3:0] TOP = DECADE ? UDC_DEC_MAX : UDC_BIN_MAX;

    // Terminal value depends on the variant, so one place decides it
    function automatic logic at_top(input logic [UDC_WIDTH-1:0] v);
        return v == TOP;
    endfunction : at_top

    typedef struct packed {
        logic [UDC_WIDTH-1:0] cnt;
        logic carry_n;
        logic borrow_n;
    } udc_state_type;

    udc_state_type st_r;
    udc_state_type st_nxt;

    udc_edge_if eif ();

    udc_edge_det u_edge (
        .clk(CLK),
        .srst(SRST),
        .up_in(COUNT_UP),
        .dn_in(COUNT_DN),
        .eif(eif)
    );

    // =====================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (CLEAR) begin
            st_nxt.cnt = UDC_ZERO;
        end else if (!LOAD_N) begin
            st_nxt.cnt = DATA;
        end else if (eif.up_rise && eif.dn_lvl) begin
            st_nxt.cnt = (st_r.cnt >= TOP) ? UDC_ZERO : st_r.cnt + UDC_ONE;
        end else if (eif.dn_rise && eif.up_lvl) begin
            st_nxt.cnt = (st_r.cnt == UDC_ZERO) ? TOP : st_r.cnt - UDC_ONE;
        end
        // Cascade outputs track the low phase of the count input at terminal value
        st_nxt.carry_n = ~(~COUNT_UP && COUNT_DN && at_top(st_nxt.cnt));
        st_nxt.borrow_n = ~(~COUNT_DN && COUNT_UP && st_nxt.cnt == UDC_ZERO);
        if (CLEAR || !LOAD_N) begin
            st_nxt.carry_n = 1'b1;
            st_nxt.borrow_n = 1'b1;
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= '{cnt: UDC_ZERO, carry_n: 1'b1, borrow_n: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign Q = st_r.cnt;
    assign CARRY_N = st_r.carry_n;
    assign BORROW_N = st_r.borrow_n;

    // =====================================================
    // Checks
    AST_CLEAR_ZERO: assert property (@(posedge CLK) disable iff (SRST)
        CLEAR |=> (Q == UDC_ZERO)) else $error("Clear did not zero count");
    AST_LOAD: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && !LOAD_N) |=> (Q == $past(DATA))) else $error("Load not taken");
    AST_UP_STEP: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.up_rise && COUNT_DN && Q < TOP)
        |=> (Q == $past(Q) + UDC_ONE)) else $error("Up step wrong");
    AST_UP_WRAP: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.up_rise && COUNT_DN && Q == TOP)
        |=> (Q == UDC_ZERO)) else $error("Up wrap wrong");
    AST_DN_WRAP: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.dn_rise && COUNT_UP && Q == UDC_ZERO)
        |=> (Q == TOP)) else $error("Down wrap wrong");
    AST_HOLD: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && !eif.up_rise && !eif.dn_rise) |=> $stable(Q))
        else $error("Count moved without edge");
    AST_CARRY: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && Q == TOP && COUNT_DN && !COUNT_UP && !eif.up_rise
         && !eif.dn_rise) |=> !CARRY_N) else $error("Carry missing");
    AST_BORROW: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && Q == UDC_ZERO && COUNT_UP && !COUNT_DN && !eif.dn_rise
         && !eif.up_rise) |=> !BORROW_N) else $error("Borrow missing");
    AST_CASCADE_IDLE: assert property (@(posedge CLK) disable iff (SRST)
        COUNT_UP && COUNT_DN |=> (CARRY_N && BORROW_N)) else $error("Cascade low at idle");

    // =====================================================
    // Counting steps and refusals
    AST_DN_STEP: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.dn_rise && COUNT_UP && !eif.up_rise
         && Q != UDC_ZERO)
        |=> (Q == $past(Q) - UDC_ONE))
        else $error("Down step wrong");
    AST_UP_ABOVE_TOP: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.up_rise && COUNT_DN && Q > TOP)
        |=> (Q == UDC_ZERO))
        else $error("Up from above top did not wrap");
    AST_UP_REFUSED: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.up_rise && !COUNT_DN && !eif.dn_rise)
        |=> $stable(Q))
        else $error("Up edge taken with down line low");
    AST_DN_REFUSED: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && LOAD_N && eif.dn_rise && !COUNT_UP && !eif.up_rise)
        |=> $stable(Q))
        else $error("Down edge taken with up line low");
    AST_UP_RISE_SRC: assert property (@(posedge CLK) disable iff (SRST)
        eif.up_rise
        |-> (COUNT_UP && !$past(COUNT_UP)))
        else $error("Up edge without a rising input");
    AST_DN_RISE_SRC: assert property (@(posedge CLK) disable iff (SRST)
        eif.dn_rise
        |-> (COUNT_DN && !$past(COUNT_DN)))
        else $error("Down edge without a rising input");

    // =====================================================
    // Clear and load priority
    AST_CLEAR_PRIO: assert property (@(posedge CLK) disable iff (SRST)
        (CLEAR && !LOAD_N)
        |=> (Q == UDC_ZERO))
        else $error("Load beat clear");
    AST_CLEAR_FLAGS: assert property (@(posedge CLK) disable iff (SRST)
        CLEAR
        |=> (CARRY_N && BORROW_N))
        else $error("Cascade low during clear");
    AST_CLEAR_HOLD: assert property (@(posedge CLK) disable iff (SRST)
        (CLEAR && $past(CLEAR))
        |-> (Q == UDC_ZERO))
        else $error("Count not low under clear");
    AST_LOAD_FLAGS: assert property (@(posedge CLK) disable iff (SRST)
        !LOAD_N
        |=> (CARRY_N && BORROW_N))
        else $error("Cascade low during load");
    AST_LOAD_OVER_COUNT: assert property (@(posedge CLK) disable iff (SRST)
        (!CLEAR && !LOAD_N && (eif.up_rise || eif.dn_rise))
        |=> (Q == $past(DATA)))
        else $error("Count pulse beat load");
    AST_LOAD_HOLD: assert property (@(posedge CLK) disable iff (SRST)
        (!LOAD_N && !$past(LOAD_N) && !$past(CLEAR) && !$past(SRST))
        |-> (Q == $past(DATA)))
        else $error("Count does not follow data under load");

    // =====================================================
    // Cascade outputs
    AST_CARRY_AT_TOP: assert property (@(posedge CLK) disable iff (SRST)
        !CARRY_N
        |-> at_top(Q))
        else $error("Carry away from top");
    AST_BORROW_AT_ZERO: assert property (@(posedge CLK) disable iff (SRST)
        !BORROW_N
        |-> (Q == UDC_ZERO))
        else $error("Borrow away from zero");
    AST_CARRY_SRC: assert property (@(posedge CLK) disable iff (SRST)
        !CARRY_N
        |-> (!$past(COUNT_UP) && $past(COUNT_DN)))
        else $error("Carry without up low phase");
    AST_BORROW_SRC: assert property (@(posedge CLK) disable iff (SRST)
        !BORROW_N
        |-> (!$past(COUNT_DN) && $past(COUNT_UP)))
        else $error("Borrow without down low phase");
    AST_CARRY_END: assert property (@(posedge CLK) disable iff (SRST)
        COUNT_UP
        |=> CARRY_N)
        else $error("Carry outlived up low phase");
    AST_BORROW_END: assert property (@(posedge CLK) disable iff (SRST)
        COUNT_DN
        |=> BORROW_N)
        else $error("Borrow outlived down low phase");
    AST_NOT_BOTH: assert property (@(posedge CLK) disable iff (SRST)
        (CARRY_N || BORROW_N))
        else $error("Carry and borrow low together");
    AST_WRAP_AFTER_CARRY: assert property (@(posedge CLK) disable iff (SRST)
        (!CARRY_N && !CLEAR && LOAD_N && eif.up_rise && COUNT_DN)
        |=> (Q == UDC_ZERO))
        else $error("No wrap after carry");
    AST_WRAP_AFTER_BORROW: assert property (@(posedge CLK) disable iff (SRST)
        (!BORROW_N && !CLEAR && LOAD_N && eif.dn_rise && COUNT_UP && !eif.up_rise)
        |=> (Q == TOP))
        else $error("No wrap after borrow");

    // =====================================================
    // Reset
    AST_RESET_VALUE: assert property (@(posedge CLK)
        SRST
        |=> (Q == UDC_ZERO && CARRY_N && BORROW_N))
        else $error("Reset values wrong");
    AST_RESET_RELEASE: assert property (@(posedge CLK)
        $fell(SRST)
        |-> (Q == UDC_ZERO && CARRY_N && BORROW_N))
        else $error("Wrong values at reset release");
endmodule : udc_counter

// ### verif/udc_drv.sv
// Count-pulse driver standing in for the upstream logic
`timescale 1ns/1ps
module udc_drv (
    // Clock
    input wire logic CLK,
    // Count lines
    output logic COUNT_UP,
    output logic COUNT_DN
);
    initial begin
        COUNT_UP = 1'b1;
        COUNT_DN = 1'b1;
    end
    // Idle line stays high so the pulse is never refused
    task automatic pulse(input bit d);
        @(posedge CLK) #1;
        if (d) COUNT_DN = 1'b0;
        else COUNT_UP = 1'b0;
        repeat (2) @(posedge CLK);
        #1 {COUNT_UP, COUNT_DN} = 2'b11;
        repeat (3) @(posedge CLK);
    endtask : pulse
endmodule : udc_drv

// ### verif/tb.sv
// Self-checking bench for the up/down counter, binary and decade variants
`timescale 1ns/1ps
module tb
    import udc_pkg::*;
;
    // ====
    // Stimulus and instances
    logic clk = 1'b0, srst = 1'b1, clear = 1'b0, load_n = 1'b1;
    logic [3:0] data = 4'h0, q;
    logic up, dn, carry_n, borrow_n;
    logic [3:0] qd;
    logic carry_d_n, borrow_d_n;
    int n_fail = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    udc_drv u_udc_drv (.CLK(clk), .COUNT_UP(up), .COUNT_DN(dn));
    udc_counter #(.DECADE(1'b0)) u_udc_counter (.CLK(clk), .SRST(srst), .COUNT_UP(up),
        .COUNT_DN(dn), .CLEAR(clear), .LOAD_N(load_n), .DATA(data), .Q(q),
        .CARRY_N(carry_n), .BORROW_N(borrow_n));
    // Decade variant shares every input with the binary one
    udc_counter #(.DECADE(1'b1)) u_udc_counter_dec (.CLK(clk), .SRST(srst), .COUNT_UP(up),
        .COUNT_DN(dn), .CLEAR(clear), .LOAD_N(load_n), .DATA(data), .Q(qd),
        .CARRY_N(carry_d_n), .BORROW_N(borrow_d_n));
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Flag is judged just after the rise, before the register clears it; count after the pulse
    task automatic step(input bit d, inout logic [3:0] e, inout logic [3:0] ed);
        logic f;
        logic fd;
        f = d ? (e == UDC_ZERO) : (e == UDC_BIN_MAX);
        fd = d ? (ed == UDC_ZERO) : (ed == UDC_DEC_MAX);
        e = d ? e - UDC_ONE : e + UDC_ONE;
        if (d) ed = (ed == UDC_ZERO) ? UDC_DEC_MAX : ed - UDC_ONE;
        else ed = (ed >= UDC_DEC_MAX) ? UDC_ZERO : ed + UDC_ONE;
        fork
            u_udc_drv.pulse(d);
            begin
                repeat (3) @(posedge clk);
                #2 chk("flag_n", {3'h0, ~f}, {3'h0, d ? borrow_n : carry_n});
                chk("flag_dec_n", {3'h0, ~fd}, {3'h0, d ? borrow_d_n : carry_d_n});
            end
        join
        #2 chk("q", e, q);
        chk("q_dec", ed, qd);
    endtask : step
    task automatic t_preset();
        @(posedge clk) #1;
        data = 4'hd;
        load_n = 1'b0;
        clear = 1'b1;
        u_udc_drv.pulse(1'b1);
        #2 chk("q_clear", UDC_ZERO, q);
        chk("q_dec_clear", UDC_ZERO, qd);
        @(posedge clk) #1 clear = 1'b0;
        repeat (3) @(posedge clk);
        #2 chk("q_load", 4'hd, q);
        chk("q_dec_load", 4'hd, qd);
        @(posedge clk) #1 load_n = 1'b1;
        $display("test preset done");
    endtask : t_preset
    task automatic t_count();
        logic [3:0] e;
        logic [3:0] ed;
        e = 4'hd;
        ed = 4'hd;
        repeat (5) step(1'b0, e, ed);
        repeat (5) step(1'b1, e, ed);
        $display("test count done");
    endtask : t_count
    task automatic t_decade();
        logic [3:0] e;
        logic [3:0] ed;
        e = 4'h7;
        ed = 4'h7;
        @(posedge clk) #1;
        data = 4'h7;
        load_n = 1'b0;
        u_udc_drv.pulse(1'b0);
        #2 chk("q_load_count", 4'h7, q);
        chk("q_dec_load_count", 4'h7, qd);
        @(posedge clk) #1 load_n = 1'b1;
        repeat (5) step(1'b0, e, ed);
        repeat (5) step(1'b1, e, ed);
        $display("test decade done");
    endtask : t_decade
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        chk("q_reset", UDC_ZERO, q);
        chk("q_dec_reset", UDC_ZERO, qd);
        t_preset();
        t_count();
        t_decade();
        tally_and_finish();
    end
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
endmodule : tb
